// >>> dozq_map.svh
// offsets, field positions, reset values and timing counts of the termination and calibration block
`ifndef DOZQ_MAP_SVH
`define DOZQ_MAP_SVH

// wishbone register offsets (byte addresses)
`define DOZQ_CTRL_OFS     8'h00
`define DOZQ_MR1_OFS      8'h04
`define DOZQ_MR2_OFS      8'h08
`define DOZQ_MR5_OFS      8'h0C
`define DOZQ_LAT_OFS      8'h10
`define DOZQ_STAT_OFS     8'h14

// mode register field positions
`define DOZQ_NOM_HI       10
`define DOZQ_NOM_LO       8
`define DOZQ_WR_HI        11
`define DOZQ_WR_LO        9
`define DOZQ_PARK_HI      8
`define DOZQ_PARK_LO      6
`define DOZQ_TDQS_BIT     11
`define DOZQ_ODTIGN_B2    9
`define DOZQ_ODTIGN_B1    6
`define DOZQ_ODTIGN_B0    2

// latency register fields: cwl[4:0], al[9:5], pl[12:10], preamble 2ck at 13
`define DOZQ_CWL_LO       0
`define DOZQ_AL_LO        5
`define DOZQ_PL_LO        10
`define DOZQ_PRE2_BIT     13

// control register bits
`define DOZQ_CTRL_X8_BIT  0
`define DOZQ_CTRL_DLL_BIT 1

// reset values
`define DOZQ_MR_RST       16'h0000
`define DOZQ_LAT_RST      16'h0009
`define DOZQ_CTRL_RST     16'h0003

// write termination lengths and preamble trims, in clocks
`define DOZQ_WR_BC4_CK    4
`define DOZQ_WR_BL8_CK    6
`define DOZQ_PRE1_TRIM    2
`define DOZQ_PRE2_TRIM    3

// calibration windows in clocks
`define DOZQ_ZQINIT_CK    1024
`define DOZQ_ZQOPER_CK    512
`define DOZQ_ZQCS_CK      64

`endif

// >>> dozq_pkg.sv
// types shared by the termination and calibration block
package dozq_pkg;

  // termination actually applied to the data pins
  typedef enum logic [1:0] {
    DOZQ_TERM_HIZ  = 2'b00,
    DOZQ_TERM_PARK = 2'b01,
    DOZQ_TERM_NOM  = 2'b10,
    DOZQ_TERM_WR   = 2'b11
  } dozq_term_t;

  // calibration command kinds
  typedef enum logic [1:0] {
    DOZQ_CAL_NONE  = 2'b00,
    DOZQ_CAL_LONG  = 2'b01,
    DOZQ_CAL_SHORT = 2'b10
  } dozq_cal_t;

endpackage

// >>> dozq_cal_if.sv
// calibration start and busy signals between the top and its calibration sequencer
`timescale 1ns/10ps
interface dozq_cal_if;
  logic       start;
  dozq_pkg::dozq_cal_t kind;
  logic       busy;
  logic       done;

  modport ctrl (output start, output kind, input busy, input done);
  modport seq  (input start, input kind, output busy, output done);
endinterface

// >>> dozq_delay_line.sv
// programmable delay of a one-bit level by lat_i plus one clocks, up to 64 clocks
`timescale 1ns/10ps
module dozq_delay_line (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // level in and delay
  input  wire logic       d_i,
  input  wire logic [5:0] lat_i,
  // delayed level
  output logic            q_o
);
  logic [63:0] sh_reg;
  logic [63:0] sh_next;
  logic        q_reg;
  logic        q_next;

  // shift history and pick the tap
  always_comb begin
    sh_next = {sh_reg[62:0], d_i};
    q_next  = (lat_i == 6'h00) ? d_i : sh_reg[lat_i - 6'h01];
  end

  // register the history
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sh_reg <= 64'h0;
      q_reg  <= 1'b0;
    end else begin
      sh_reg <= sh_next;
      q_reg  <= q_next;
    end
  end

  assign q_o = q_reg;
endmodule // dozq_delay_line

// >>> dozq_zq_seq.sv
// calibration window counter: long and short calibration with first-after-reset tracking
`timescale 1ns/10ps
`include "dozq_map.svh"
module dozq_zq_seq
  import dozq_pkg::*;
(
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // calibration link to the top
  dozq_cal_if.seq   cal,
  // calibration current path enable
  output logic      zq_current_o
);
  logic [10:0] cnt_reg;
  logic [10:0] cnt_next;
  logic        first_reg;
  logic        first_next;
  logic        done_reg;
  logic        done_next;

  // load the window length by kind, count down, end with current off
  always_comb begin
    cnt_next   = cnt_reg;
    first_next = first_reg;
    done_next  = 1'b0;
    if (cnt_reg == 11'h000 && cal.start) begin
      if (cal.kind == DOZQ_CAL_LONG) begin
        cnt_next   = first_reg ? 11'(`DOZQ_ZQINIT_CK) : 11'(`DOZQ_ZQOPER_CK);
        first_next = 1'b0;
      end else if (cal.kind == DOZQ_CAL_SHORT) begin
        cnt_next = 11'(`DOZQ_ZQCS_CK);
      end
    end else if (cnt_reg != 11'h000) begin
      cnt_next  = cnt_reg - 11'h001;
      done_next = (cnt_reg == 11'h001);
    end
  end

  // register counter state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_reg   <= 11'h000;
      first_reg <= 1'b1;
      done_reg  <= 1'b0;
    end else begin
      cnt_reg   <= cnt_next;
      first_reg <= first_next;
      done_reg  <= done_next;
    end
  end

  assign cal.busy     = (cnt_reg != 11'h000);
  assign cal.done     = done_reg;
  assign zq_current_o = (cnt_reg != 11'h000);
endmodule // dozq_zq_seq

// >>> dozq_odt_zq_ctrl.sv
// termination selection and calibration control with a wishbone register file
//
// Decided for this implementation: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/10ps
`include "dozq_map.svh"
// What this block does
// - first long calibration finishes within the init window, later ones within operational window.
// - each short calibration finishes within 64 clocks.
// - no automatic recalibration after self refresh exit; only explicit commands.
// - termination is forced off during calibration if the controller leaves it on.
// - calibration current path is switched off once calibration completes.
// - in self refresh termination is off and the ODT pin ignored.
// - ODT pin ignored when nominal disable bits 9, 6 and 2 are all zero.
// - termination enabled when park field non-zero, write field 1 to 3, or nominal field non-zero with bit 9, 6 or 2 set.
// - write termination applies for its window after WRITE regardless of ODT pin.
// - priority: disabled, then write, then nominal, then park.
// - idle: ODT high gives nominal, else park if enabled, else high impedance.
// - during a read window termination is high impedance.
// - ODT receiver powered down when nominal termination is disabled.
// - nominal and park code 240 to 34 ohm; write codes 240, 120, 80 only.
// - x8 strobe pair terminated only when MR1 bit 11 is one.
// - synchronous ODT timing whenever DLL on and locked.
// - nominal switches DODTLon after ODT high, DODTLoff after low.
// - direct latency is CWL+AL+PL minus 2, or minus 3 with 2-clock preamble.
// - write termination starts WL-2 after WRITE (WL-3 with 2-clock preamble) and lasts 4 or 6 clocks.
module dozq_odt_zq_ctrl
  import dozq_pkg::*;
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // device command decode and pins
  input  wire logic        odt_i,
  input  wire logic        cmd_wr_i,
  input  wire logic        cmd_wr_bl8_i,
  input  wire logic        cmd_rd_i,
  input  wire logic        cmd_zqcl_i,
  input  wire logic        cmd_zqcs_i,
  input  wire logic        self_refresh_i,
  input  wire logic        dll_locked_i,
  input  wire logic [5:0]  rd_window_ck_i,
  // termination and calibration outputs
  output dozq_term_t       term_o,
  output logic      [2:0]  term_code_o,
  output logic             tdqs_term_o,
  output logic             odt_rx_en_o,
  output logic             sync_odt_o,
  output logic             cal_busy_o,
  output logic             zq_current_o
);
  dozq_cal_if cal ();

  logic [15:0] ctrl_reg;
  logic [15:0] ctrl_next;
  logic [15:0] mr1_reg;
  logic [15:0] mr1_next;
  logic [15:0] mr2_reg;
  logic [15:0] mr2_next;
  logic [15:0] mr5_reg;
  logic [15:0] mr5_next;
  logic [15:0] lat_reg;
  logic [15:0] lat_next;
  logic [31:0] dat_reg;
  logic [31:0] dat_next;
  logic        ack_reg;
  logic        ack_next;
  logic [2:0]  nom_code;
  logic [2:0]  wr_code;
  logic [2:0]  park_code;
  logic        nom_en;
  logic        wr_en;
  logic        park_en;
  logic        odt_use;
  logic        odt_dly;
  logic [6:0]  lat_sum;
  logic [5:0]  dodtl;
  logic [5:0]  wr_start;
  logic [3:0]  wr_len_reg;
  logic [3:0]  wr_len_next;
  logic [5:0]  wr_wait_reg;
  logic [5:0]  wr_wait_next;
  logic [3:0]  wr_on_reg;
  logic [3:0]  wr_on_next;
  logic [5:0]  rd_cnt_reg;
  logic [5:0]  rd_cnt_next;
  dozq_term_t  term_reg;
  dozq_term_t  term_next;
  logic [2:0]  code_reg;
  logic [2:0]  code_next;
  logic        wb_hit;

  // mode register fields and enables
  always_comb begin
    nom_code  = mr1_reg[`DOZQ_NOM_HI:`DOZQ_NOM_LO];
    wr_code   = mr2_reg[`DOZQ_WR_HI:`DOZQ_WR_LO];
    park_code = mr5_reg[`DOZQ_PARK_HI:`DOZQ_PARK_LO];
    nom_en    = (mr1_reg[`DOZQ_ODTIGN_B2] | mr1_reg[`DOZQ_ODTIGN_B1] | mr1_reg[`DOZQ_ODTIGN_B0])
                & (nom_code != 3'h0);
    wr_en     = (wr_code != 3'h0) && (wr_code <= 3'h3);
    park_en   = (park_code != 3'h0);
  end

  // direct latency: cwl+al+pl less preamble trim
  always_comb begin
    lat_sum = 7'(lat_reg[`DOZQ_CWL_LO +: 5]) + 7'(lat_reg[`DOZQ_AL_LO +: 5]) + 7'(lat_reg[`DOZQ_PL_LO +: 3]);
    if (lat_reg[`DOZQ_PRE2_BIT]) begin
      dodtl = (lat_sum > 7'h03) ? 6'(lat_sum - 7'h03) : 6'h00;
    end else begin
      dodtl = (lat_sum > 7'h02) ? 6'(lat_sum - 7'h02) : 6'h00;
    end
    wr_start = dodtl;
  end

  // odt pin gated by self refresh and nominal disable
  assign odt_use = odt_i & nom_en & ~self_refresh_i;

  // nominal termination follows the pin after the direct latency
  dozq_delay_line u_odt_dly (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   (odt_use),
    .lat_i (dodtl),
    .q_o   (odt_dly)
  );

  // calibration start, no self-started recalibration
  assign cal.start = (cmd_zqcl_i | cmd_zqcs_i) & ~self_refresh_i;
  assign cal.kind  = cmd_zqcl_i ? DOZQ_CAL_LONG : (cmd_zqcs_i ? DOZQ_CAL_SHORT : DOZQ_CAL_NONE);

  dozq_zq_seq u_zq (
    .clk_i        (clk_i),
    .rst_i        (rst_i),
    .cal          (cal),
    .zq_current_o (zq_current_o)
  );

  // write and read termination windows
  always_comb begin
    wr_wait_next = wr_wait_reg;
    wr_on_next   = wr_on_reg;
    wr_len_next  = wr_len_reg;
    rd_cnt_next  = (rd_cnt_reg != 6'h00) ? rd_cnt_reg - 6'h01 : 6'h00;
    if (wr_wait_reg != 6'h00) begin
      wr_wait_next = wr_wait_reg - 6'h01;
      if (wr_wait_reg == 6'h01) begin
        wr_on_next = wr_len_reg;
      end
    end else if (wr_on_reg != 4'h0) begin
      wr_on_next = wr_on_reg - 4'h1;
    end
    if (cmd_wr_i && wr_en) begin
      wr_len_next = cmd_wr_bl8_i ? 4'(`DOZQ_WR_BL8_CK) : 4'(`DOZQ_WR_BC4_CK);
      if (wr_start == 6'h00) begin
        wr_wait_next = 6'h00;
        wr_on_next   = wr_len_next;
      end else begin
        wr_wait_next = wr_start;
      end
    end
    if (cmd_rd_i) begin
      rd_cnt_next = rd_window_ck_i;
    end
  end

  // termination priority resolution
  always_comb begin
    term_next = DOZQ_TERM_HIZ;
    code_next = 3'h0;
    if (self_refresh_i || cal.busy || rd_cnt_reg != 6'h00) begin
      term_next = DOZQ_TERM_HIZ;
    end else if (wr_on_reg != 4'h0) begin
      term_next = DOZQ_TERM_WR;
      code_next = wr_code;
    end else if (odt_dly && nom_en) begin
      term_next = DOZQ_TERM_NOM;
      code_next = nom_code;
    end else if (park_en) begin
      term_next = DOZQ_TERM_PARK;
      code_next = park_code;
    end
  end

  // wishbone register writes and read data
  assign wb_hit = cyc_i & stb_i & ~ack_reg;
  always_comb begin
    ctrl_next = ctrl_reg;
    mr1_next  = mr1_reg;
    mr2_next  = mr2_reg;
    mr5_next  = mr5_reg;
    lat_next  = lat_reg;
    dat_next  = 32'h0;
    ack_next  = wb_hit;
    if (wb_hit && we_i) begin
      unique case (adr_i)
        `DOZQ_CTRL_OFS: ctrl_next = {sel_i[1] ? dat_i[15:8] : ctrl_reg[15:8], sel_i[0] ? dat_i[7:0] : ctrl_reg[7:0]};
        `DOZQ_MR1_OFS:  mr1_next  = {sel_i[1] ? dat_i[15:8] : mr1_reg[15:8], sel_i[0] ? dat_i[7:0] : mr1_reg[7:0]};
        `DOZQ_MR2_OFS:  mr2_next  = {sel_i[1] ? dat_i[15:8] : mr2_reg[15:8], sel_i[0] ? dat_i[7:0] : mr2_reg[7:0]};
        `DOZQ_MR5_OFS:  mr5_next  = {sel_i[1] ? dat_i[15:8] : mr5_reg[15:8], sel_i[0] ? dat_i[7:0] : mr5_reg[7:0]};
        `DOZQ_LAT_OFS:  lat_next  = {sel_i[1] ? dat_i[15:8] : lat_reg[15:8], sel_i[0] ? dat_i[7:0] : lat_reg[7:0]};
        default: ;
      endcase
    end
    if (wb_hit && !we_i) begin
      unique case (adr_i)
        `DOZQ_CTRL_OFS: dat_next = {16'h0, ctrl_reg};
        `DOZQ_MR1_OFS:  dat_next = {16'h0, mr1_reg};
        `DOZQ_MR2_OFS:  dat_next = {16'h0, mr2_reg};
        `DOZQ_MR5_OFS:  dat_next = {16'h0, mr5_reg};
        `DOZQ_LAT_OFS:  dat_next = {16'h0, lat_reg};
        `DOZQ_STAT_OFS: dat_next = {24'h0, zq_current_o, cal.busy, term_reg, code_reg, odt_dly};
        default:        dat_next = 32'h0;
      endcase
    end
  end

  // register all state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg    <= `DOZQ_CTRL_RST;
      mr1_reg     <= `DOZQ_MR_RST;
      mr2_reg     <= `DOZQ_MR_RST;
      mr5_reg     <= `DOZQ_MR_RST;
      lat_reg     <= `DOZQ_LAT_RST;
      dat_reg     <= 32'h0;
      ack_reg     <= 1'b0;
      wr_len_reg  <= 4'h0;
      wr_wait_reg <= 6'h00;
      wr_on_reg   <= 4'h0;
      rd_cnt_reg  <= 6'h00;
      term_reg    <= DOZQ_TERM_HIZ;
      code_reg    <= 3'h0;
    end else begin
      ctrl_reg    <= ctrl_next;
      mr1_reg     <= mr1_next;
      mr2_reg     <= mr2_next;
      mr5_reg     <= mr5_next;
      lat_reg     <= lat_next;
      dat_reg     <= dat_next;
      ack_reg     <= ack_next;
      wr_len_reg  <= wr_len_next;
      wr_wait_reg <= wr_wait_next;
      wr_on_reg   <= wr_on_next;
      rd_cnt_reg  <= rd_cnt_next;
      term_reg    <= term_next;
      code_reg    <= code_next;
    end
  end

  // outputs
  assign dat_o        = dat_reg;
  assign ack_o        = ack_reg;
  assign term_o       = term_reg;
  assign term_code_o  = code_reg;
  assign tdqs_term_o  = ctrl_reg[`DOZQ_CTRL_X8_BIT] & mr1_reg[`DOZQ_TDQS_BIT] & (term_reg != DOZQ_TERM_HIZ);
  assign odt_rx_en_o  = nom_en & ~self_refresh_i;
  assign sync_odt_o   = dll_locked_i & ctrl_reg[`DOZQ_CTRL_DLL_BIT];
  assign cal_busy_o   = cal.busy;
endmodule // dozq_odt_zq_ctrl

// >>> dozq_odt_zq_ctrl_monitor.sv
// checker for termination and calibration behaviour at the block ports
`timescale 1ns/10ps
`include "dozq_map.svh"
module dozq_odt_zq_ctrl_monitor
  import dozq_pkg::*;
(
  // clock, reset and bus handshake
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       cyc_i,
  input wire logic       stb_i,
  input wire logic       ack_o,
  // commands
  input wire logic       cmd_rd_i,
  input wire logic [5:0] rd_window_ck_i,
  input wire logic       cmd_zqcl_i,
  input wire logic       cmd_zqcs_i,
  input wire logic       self_refresh_i,
  // watched outputs
  input wire dozq_term_t term_o,
  input wire logic [2:0] term_code_o,
  input wire logic       cal_busy_o,
  input wire logic       zq_current_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic        take;
  logic        first_reg;
  logic [10:0] len_reg;
  logic [10:0] want_reg;
  // calibration command the block must accept
  assign take = !cal_busy_o && !self_refresh_i && (cmd_zqcl_i || cmd_zqcs_i);
  // busy length and the window owed to the last accepted command
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      first_reg <= 1'b1;
      want_reg  <= 11'h000;
    end else if (take) begin
      first_reg <= first_reg & ~cmd_zqcl_i;
      want_reg  <= !cmd_zqcl_i ? 11'(`DOZQ_ZQCS_CK) : first_reg ? 11'(`DOZQ_ZQINIT_CK) : 11'(`DOZQ_ZQOPER_CK);
    end
    len_reg <= (cal_busy_o && !rst_i) ? len_reg + 11'h001 : 11'h000;
  end
  sequence s_take; take; endsequence
  sequence s_cal; cal_busy_o && zq_current_o ##1 term_o == DOZQ_TERM_HIZ; endsequence
  property p_ack; cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o; endproperty
  a_ack: assert property (p_ack) else $error("bus answer not one cycle");
  property p_start; s_take |=> s_cal; endproperty
  a_start: assert property (p_start) else $error("calibration did not start");
  property p_len; $fell(cal_busy_o) |-> len_reg == want_reg; endproperty
  a_len: assert property (p_len) else $error("calibration window length");
  property p_hiz; cal_busy_o |=> term_o == DOZQ_TERM_HIZ; endproperty
  a_hiz: assert property (p_hiz) else $error("termination on in calibration");
  property p_auto; $rose(cal_busy_o) |-> $past(take); endproperty
  a_auto: assert property (p_auto) else $error("calibration without command");
  property p_cur; zq_current_o |-> cal_busy_o && len_reg < want_reg; endproperty
  a_cur: assert property (p_cur) else $error("current path left on");
  property p_sr; self_refresh_i |=> term_o == DOZQ_TERM_HIZ; endproperty
  a_sr: assert property (p_sr) else $error("termination in self refresh");
  property p_rd; cmd_rd_i && rd_window_ck_i != 6'h00 |-> ##2 term_o == DOZQ_TERM_HIZ; endproperty
  a_rd: assert property (p_rd) else $error("termination during read");
  property p_wrc; term_o == DOZQ_TERM_WR |-> term_code_o inside {3'h1, 3'h2, 3'h3}; endproperty
  a_wrc: assert property (p_wrc) else $error("bad write code");
endmodule // dozq_odt_zq_ctrl_monitor
bind dozq_odt_zq_ctrl dozq_odt_zq_ctrl_monitor i_dozq_odt_zq_ctrl_monitor (.clk_i(clk_i), .rst_i(rst_i),
  .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o), .cmd_rd_i(cmd_rd_i), .rd_window_ck_i(rd_window_ck_i),
  .cmd_zqcl_i(cmd_zqcl_i), .cmd_zqcs_i(cmd_zqcs_i), .self_refresh_i(self_refresh_i), .term_o(term_o),
  .term_code_o(term_code_o), .cal_busy_o(cal_busy_o), .zq_current_o(zq_current_o));

// >>> dozq_mc_model.sv
// memory controller model driving commands and the odt pin
`timescale 1ns/10ps
module dozq_mc_model #(
  parameter int TXSF_CK = 12 // self refresh exit time, plain default
) (
  // clock
  input  wire logic  clk_i,
  // pins toward the block
  output logic       odt_o,
  output logic [3:0] cmd_o, // write, read, long, short
  output logic       bl8_o,
  output logic       sr_o,
  output logic       dll_o,
  output logic [5:0] rdw_o
);
  // idle channel, dll locked, self refresh off
  initial begin
    {odt_o, cmd_o, bl8_o, sr_o, dll_o, rdw_o} = {8'h01, 6'h00};
  end
  // one-cycle command pulse; a picks the long burst and the long read window
  task cmd(input int k, input logic a);
    @(posedge clk_i);
    {cmd_o, bl8_o, rdw_o} <= {4'h8 >> k, a, a ? 6'h09 : 6'h05};
    @(posedge clk_i);
    cmd_o <= 4'h0;
  endtask
  // calibration only after precharge-all and tRP, channel quiet around it
  task zq(input int k);
    repeat (4) @(posedge clk_i);
    cmd(k, 1'b0);
  endtask
  // odt level; callers hold it high long enough
  task odt(input logic v);
    @(posedge clk_i);
    odt_o <= v;
  endtask
  // self refresh; nothing issued before the exit time
  task sr(input logic v);
    @(posedge clk_i);
    sr_o <= v;
    if (!v) repeat (TXSF_CK) @(posedge clk_i);
  endtask
  // dll lock level
  task lock(input logic v);
    @(posedge clk_i);
    dll_o <= v;
  endtask
endmodule // dozq_mc_model

// >>> dozq_odt_zq_ctrl_test.sv
// self-checking bench for the termination and calibration block
`timescale 1ns/10ps
`include "dozq_map.svh"
module dozq_odt_zq_ctrl_test
  import dozq_pkg::*;
;
  logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o;
  logic [7:0]  adr_i;
  logic [3:0]  sel_i, cmd;
  logic [31:0] dat_i, dat_o, q;
  logic        odt, bl8, sr, dll, tdqs, rxen, sync, busy, zqcur;
  logic [5:0]  rdw;
  logic [2:0]  code;
  dozq_term_t  term;
  int          fail_count, checks, i, n;
  dozq_mc_model i_dozq_mc_model (.clk_i(clk_i), .odt_o(odt), .cmd_o(cmd), .bl8_o(bl8), .sr_o(sr),
    .dll_o(dll), .rdw_o(rdw));
  dozq_odt_zq_ctrl i_dozq_odt_zq_ctrl (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .odt_i(odt),
    .cmd_wr_i(cmd[3]), .cmd_wr_bl8_i(bl8), .cmd_rd_i(cmd[2]), .cmd_zqcl_i(cmd[1]), .cmd_zqcs_i(cmd[0]),
    .self_refresh_i(sr), .dll_locked_i(dll), .rd_window_ck_i(rdw), .term_o(term), .term_code_o(code),
    .tdqs_term_o(tdqs), .odt_rx_en_o(rxen), .sync_odt_o(sync), .cal_busy_o(busy), .zq_current_o(zqcur));
  // clock
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  // verdict and end of run
  task results;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // compare and count
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  // let k edges pass, then sample settled outputs
  task at(input int k);
    repeat (k) @(posedge clk_i);
    #1;
  endtask
  // termination state and code
  task tm(input dozq_term_t e, input logic [2:0] c);
    chk("term", e, term);
    chk("code", c, code);
  endtask
  // classic wishbone cycle held until ack is sampled
  task wb(input logic w, input logic [7:0] a, input logic [15:0] d);
    int k;
    k = 0;
    @(posedge clk_i);
    {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'b11, w, a, 16'h0000, d};
    do begin
      @(posedge clk_i);
      k++;
    end while (ack_o !== 1'b1 && k < 20);
    q = dat_o;
    {cyc_i, stb_i, we_i} <= 3'b000;
    chk("ack", 1, ack_o);
  endtask
  // register read against an expected value
  task rdc(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 16'h0000);
    chk("register", e, q);
  endtask
  // calibration window measured, optionally with a short calibration command issued inside it
  task cal(input int k, input logic extra, input int len);
    i_dozq_mc_model.zq(k);
    n = 1;
    if (extra) begin
      i_dozq_mc_model.cmd(3, 1'b0);
      n = 3;
    end
    #1;
    chk("busy", 1, busy & zqcur);
    while (busy === 1'b1 && n < 1100) begin
      at(1);
      n++;
      if (n == 2) chk("term", DOZQ_TERM_HIZ, term);
    end
    chk("window", len + 1, n);
  endtask
  // cut a hang short
  initial begin
    repeat (8000) @(posedge clk_i);
    fail_count++;
    results();
  end
  // main sequence
  initial begin
    {rst_i, cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} = {4'h8, 8'h00, 4'h3, 32'h0000_0000};
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    at(1);
    tm(DOZQ_TERM_HIZ, 3'h0);
    wb(1'b1, 8'h18, 16'hFFFF);
    rdc(8'h18, 32'h0000_0000);
    for (i = 0; i < 5; i++) rdc(8'(4 * i), i == 0 ? `DOZQ_CTRL_RST : i == 4 ? `DOZQ_LAT_RST : `DOZQ_MR_RST);
    sel_i <= 4'h1;
    wb(1'b1, `DOZQ_MR1_OFS, 16'hFF04);
    sel_i <= 4'h2;
    wb(1'b1, `DOZQ_MR1_OFS, 16'h0BAA);
    sel_i <= 4'h3;
    wb(1'b1, `DOZQ_MR2_OFS, 16'h0400);
    wb(1'b1, `DOZQ_MR5_OFS, 16'h0140);
    rdc(`DOZQ_MR1_OFS, 32'h0000_0B04);
    at(3);
    tm(DOZQ_TERM_PARK, 3'h5);
    chk("sync", 1, sync);
    i_dozq_mc_model.odt(1'b1);
    at(8);
    tm(DOZQ_TERM_PARK, 3'h5);
    at(1);
    tm(DOZQ_TERM_NOM, 3'h3);
    chk("tdqs", 1, tdqs & rxen);
    wb(1'b1, `DOZQ_CTRL_OFS, 16'h0002);
    at(1);
    chk("tdqs", 0, tdqs);
    wb(1'b1, `DOZQ_CTRL_OFS, 16'h0003);
    // short burst with odt high, then long burst with odt low
    for (i = 0; i < 2; i++) begin
      if (i == 1) begin
        i_dozq_mc_model.odt(1'b0);
        at(12);
      end
      i_dozq_mc_model.cmd(0, i == 1);
      at(7);
      chk("term", i ? DOZQ_TERM_PARK : DOZQ_TERM_NOM, term);
      at(1);
      tm(DOZQ_TERM_WR, 3'h2);
      at(i ? 5 : 3);
      chk("term", DOZQ_TERM_WR, term);
      at(1);
      chk("term", i ? DOZQ_TERM_PARK : DOZQ_TERM_NOM, term);
    end
    i_dozq_mc_model.cmd(1, 1'b0);
    at(1);
    chk("term", DOZQ_TERM_HIZ, term);
    at(4);
    chk("term", DOZQ_TERM_HIZ, term);
    at(1);
    chk("term", DOZQ_TERM_PARK, term);
    i_dozq_mc_model.cmd(1, 1'b1);
    at(9);
    chk("term", DOZQ_TERM_HIZ, term);
    at(1);
    chk("term", DOZQ_TERM_PARK, term);
    // write code beyond the write range leaves termination alone
    wb(1'b1, `DOZQ_MR2_OFS, 16'h0800);
    i_dozq_mc_model.cmd(0, 1'b0);
    at(9);
    tm(DOZQ_TERM_PARK, 3'h5);
    // odt left high on purpose: the block must drop termination itself
    i_dozq_mc_model.odt(1'b1);
    at(12);
    cal(2, 1'b0, `DOZQ_ZQINIT_CK);
    cal(2, 1'b1, `DOZQ_ZQOPER_CK);
    cal(3, 1'b0, `DOZQ_ZQCS_CK);
    at(3);
    tm(DOZQ_TERM_NOM, 3'h3);
    chk("current", 0, zqcur);
    i_dozq_mc_model.sr(1'b1);
    at(2);
    chk("term", DOZQ_TERM_HIZ, term);
    i_dozq_mc_model.zq(2);
    at(1);
    chk("busy", 0, busy);
    i_dozq_mc_model.sr(1'b0);
    at(20);
    chk("busy", 0, busy);
    tm(DOZQ_TERM_NOM, 3'h3);
    // two-clock preamble, cwl 12, al 2
    i_dozq_mc_model.odt(1'b0);
    wb(1'b1, `DOZQ_LAT_OFS, 16'h204C);
    at(16);
    i_dozq_mc_model.odt(1'b1);
    at(12);
    chk("term", DOZQ_TERM_PARK, term);
    at(1);
    chk("term", DOZQ_TERM_NOM, term);
    wb(1'b1, `DOZQ_MR1_OFS, 16'h0100);
    at(16);
    tm(DOZQ_TERM_PARK, 3'h5);
    chk("rx", 0, rxen);
    wb(1'b1, `DOZQ_MR5_OFS, 16'h0000);
    at(3);
    chk("term", DOZQ_TERM_HIZ, term);
    i_dozq_mc_model.lock(1'b0);
    at(1);
    chk("sync", 0, sync);
    results();
  end
endmodule // dozq_odt_zq_ctrl_test
